/* rtl/itc_pkg.sv */
// Package of constants for the I2C timing configuration register block
package itc_pkg;

  // ----------------------------------------------------------------------
  // Clock and time units
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_RATE_MHZ = 50;
  localparam int unsigned TIME_W = 16;
  localparam logic [15:0] CLK_PERIOD_NS = 16'(1000 / CLK_RATE_MHZ);
  localparam logic [15:0] OSC_UNIT_NS = 16'h0032;
  localparam logic [15:0] FILT_UNIT_NS = 16'h000a;

  // ----------------------------------------------------------------------
  // Register bus geometry and register indexes
  // ----------------------------------------------------------------------
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam logic [5:0] IDX_INPUT_CTRL = 6'h10;
  localparam logic [5:0] IDX_CLK_HIGH = 6'h11;
  localparam logic [5:0] IDX_CLK_LOW = 6'h12;
  localparam logic [5:0] IDX_GP_BYTE = 6'h13;
  localparam logic [5:0] IDX_SELF_TEST = 6'h14;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ----------------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_INPUT_CTRL = 8'h17;
  localparam logic [7:0] RST_CLK_HIGH = 8'h82;
  localparam logic [7:0] RST_CLK_LOW = 8'h82;
  localparam logic [7:0] RST_GP_BYTE = 8'h00;
  localparam logic [7:0] RST_SELF_TEST = 8'h00;
  localparam logic [7:0] SELF_TEST_WMASK = 8'h1f;
  localparam int unsigned HOLD_MSB = 6;
  localparam int unsigned HOLD_LSB = 4;
  localparam int unsigned DEPTH_MSB = 3;
  localparam int unsigned DEPTH_LSB = 0;
  localparam int unsigned CLKSRC_MSB = 2;
  localparam int unsigned CLKSRC_LSB = 1;

  // ----------------------------------------------------------------------
  // Master clock generator states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MCK_IDLE = 3'b001,
    MCK_HIGH = 3'b010,
    MCK_LOW  = 3'b100
  } itc_mck_state_t;

endpackage

/* rtl/itc_glitch_filter.sv */
// Glitch filter for one synchronised I2C input line
`timescale 1ns/1ps
`default_nettype none

module itc_glitch_filter (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic line_i,
  input wire logic [3:0] depth_i,
  output logic line_o
);
  import itc_pkg::*;

  logic [TIME_W-1:0] stable_ns_r;
  logic [TIME_W-1:0] stable_ns_nxt;
  logic [TIME_W-1:0] limit_ns;

  // ----------------------------------------------------------------------
  // Pulse width measurement
  // ----------------------------------------------------------------------

  // Widest pulse to reject, in ns
  assign limit_ns = TIME_W'({12'h000, depth_i} * FILT_UNIT_NS);
  assign stable_ns_nxt = stable_ns_r + CLK_PERIOD_NS;

  // Follow the input only once it outlasts the filter depth
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      line_o <= 1'b1;
      stable_ns_r <= '0;
    end else if (ce_i) begin
      if (line_i == line_o) begin
        stable_ns_r <= '0;
      end else if (stable_ns_nxt > limit_ns) begin
        line_o <= line_i;
        stable_ns_r <= '0;
      end else begin
        stable_ns_r <= stable_ns_nxt;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/itc_timing_regs.sv */
// APB register block setting local I2C timing, filtering and clock select
`timescale 1ns/1ps
`default_nettype none

module itc_timing_regs (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [itc_pkg::REG_ADDR_W-1:0] paddr_i,
  input wire logic [itc_pkg::DATA_W-1:0] pwdata_i,
  output logic [itc_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic scl_in_o,
  output logic sda_in_o,
  input wire logic master_en_i,
  input wire logic slave_stretch_i,
  input wire logic slave_data_set_i,
  output logic slave_release_o,
  input wire logic osc_mode_i,
  input wire logic ext_clk_present_i,
  output logic [1:0] osc_freq_sel_o,
  output logic use_osc_o,
  output logic [7:0] general_purpose_bits_o
);
  import itc_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] input_ctrl_r;
  logic [7:0] clk_high_r;
  logic [7:0] clk_low_r;
  logic [7:0] gp_byte_r;
  logic [7:0] self_test_r;
  logic [IDX_W-1:0] idx;
  logic hit;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] filt;
  logic scl_prev_r;
  logic hold_busy_r;
  logic [TIME_W-1:0] hold_ns_r;
  logic [TIME_W-1:0] hold_ns_nxt;
  logic [TIME_W-1:0] hold_limit;
  itc_mck_state_t mck_state_r;
  logic [TIME_W-1:0] mck_ns_r;
  logic [TIME_W-1:0] mck_ns_nxt;
  logic [TIME_W-1:0] high_limit;
  logic [TIME_W-1:0] low_limit;
  logic mck_drive_low_r;
  logic setup_busy_r;
  logic [TIME_W-1:0] setup_ns_r;
  logic [TIME_W-1:0] setup_ns_nxt;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // True for an aligned word inside the register span
  function automatic logic reg_hit(input logic [REG_ADDR_W-1:0] a);
    logic [IDX_W-1:0] i;
    i = a[REG_ADDR_W-1:2];
    reg_hit = (a[1:0] == WORD_ALIGN) && (i >= IDX_INPUT_CTRL) &&
              (i <= IDX_SELF_TEST);
  endfunction

  // Scale a count of units to ns on the working clock
  function automatic logic [TIME_W-1:0] units_ns(input logic [7:0] cnt,
    input logic [TIME_W-1:0] unit);
    units_ns = TIME_W'({8'h00, cnt} * unit);
  endfunction

  // Register index is the byte address over four
  assign idx = paddr_i[REG_ADDR_W-1:2];
  assign hit = reg_hit(paddr_i);
  assign wr_fire = psel_i && penable_i && pready_o && pwrite_i;

  // ----------------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------------

  // One wait state, then a single ready cycle
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      if (psel_i && penable_i && !pready_o) begin
        pready_o <= 1'b1;
        pslverr_o <= !hit;
      end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // Read data mux, upper bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_INPUT_CTRL: rd_byte = input_ctrl_r;
      IDX_CLK_HIGH: rd_byte = clk_high_r;
      IDX_CLK_LOW: rd_byte = clk_low_r;
      IDX_GP_BYTE: rd_byte = gp_byte_r;
      IDX_SELF_TEST: rd_byte = self_test_r;
      default: rd_byte = 8'h00;
    endcase
    if (!hit) begin
      rd_byte = 8'h00;
    end
  end

  // Read data registered during the wait state
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      prdata_o <= '0;
    end else if (ce_i) begin
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        prdata_o <= {24'h000000, rd_byte};
      end else begin
        prdata_o <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------

  // Writes land on the ready edge only
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      input_ctrl_r <= RST_INPUT_CTRL;
      clk_high_r <= RST_CLK_HIGH;
      clk_low_r <= RST_CLK_LOW;
      gp_byte_r <= RST_GP_BYTE;
      self_test_r <= RST_SELF_TEST;
    end else if (ce_i && wr_fire && hit) begin
      unique case (idx)
        IDX_INPUT_CTRL: input_ctrl_r <= pwdata_i[7:0];
        IDX_CLK_HIGH: clk_high_r <= pwdata_i[7:0];
        IDX_CLK_LOW: clk_low_r <= pwdata_i[7:0];
        IDX_GP_BYTE: gp_byte_r <= pwdata_i[7:0];
        IDX_SELF_TEST: self_test_r <= pwdata_i[7:0] & SELF_TEST_WMASK;
        default: gp_byte_r <= gp_byte_r;
      endcase
    end
  end

  // General purpose byte and oscillator selection outputs
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      general_purpose_bits_o <= RST_GP_BYTE;
      osc_freq_sel_o <= RST_SELF_TEST[CLKSRC_MSB:CLKSRC_LSB];
      use_osc_o <= 1'b0;
      scl_o <= 1'b0;
    end else if (ce_i) begin
      general_purpose_bits_o <= gp_byte_r;
      osc_freq_sel_o <= self_test_r[CLKSRC_MSB:CLKSRC_LSB];
      use_osc_o <= osc_mode_i || !ext_clk_present_i;
      scl_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and glitch filters
  // ----------------------------------------------------------------------

  // Two flops per pin, then a filter on the second
  for (genvar g = 0; g < 2; g++) begin : g_line
    always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
        sync1_r[g] <= 1'b1;
        sync2_r[g] <= 1'b1;
      end else if (ce_i) begin
        sync1_r[g] <= (g == 0) ? scl_pin_i : sda_pin_i;
        sync2_r[g] <= sync1_r[g];
      end
    end

    // Both lines share one depth, so their relative timing holds
    itc_glitch_filter u_filter (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .line_i(sync2_r[g]),
      .depth_i(input_ctrl_r[DEPTH_MSB:DEPTH_LSB]),
      .line_o(filt[g])
    );
  end

  assign scl_in_o = filt[0];

  // ----------------------------------------------------------------------
  // Internal data hold after clock fall
  // ----------------------------------------------------------------------
  assign hold_limit =
    units_ns({5'h00, input_ctrl_r[HOLD_MSB:HOLD_LSB]}, OSC_UNIT_NS);
  assign hold_ns_nxt = hold_ns_r + CLK_PERIOD_NS;

  // Freeze sampled data for the hold time after each clock fall
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      scl_prev_r <= 1'b1;
      hold_busy_r <= 1'b0;
      hold_ns_r <= '0;
      sda_in_o <= 1'b1;
    end else if (ce_i) begin
      scl_prev_r <= filt[0];
      // A zero hold field leaves the data path transparent
      if (scl_prev_r && !filt[0] && (hold_limit != '0)) begin
        hold_busy_r <= 1'b1;
        hold_ns_r <= CLK_PERIOD_NS;
      end else if (hold_busy_r) begin
        hold_ns_r <= hold_ns_nxt;
        if (hold_ns_r >= hold_limit) begin
          hold_busy_r <= 1'b0;
          sda_in_o <= filt[1];
        end
      end else begin
        sda_in_o <= filt[1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Master clock generator
  // ----------------------------------------------------------------------
  assign high_limit = units_ns(clk_high_r, OSC_UNIT_NS);
  assign low_limit = units_ns(clk_low_r, OSC_UNIT_NS);
  assign mck_ns_nxt = mck_ns_r + CLK_PERIOD_NS;

  // High phase counts only while the line is seen high
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      mck_state_r <= MCK_IDLE;
      mck_ns_r <= '0;
      mck_drive_low_r <= 1'b0;
    end else if (ce_i) begin
      if (!master_en_i) begin
        mck_state_r <= MCK_IDLE;
        mck_ns_r <= '0;
        mck_drive_low_r <= 1'b0;
      end else begin
        unique case (mck_state_r)
          MCK_IDLE: begin
            mck_state_r <= MCK_HIGH;
            mck_ns_r <= '0;
          end
          MCK_HIGH: begin
            if (filt[0]) begin
              mck_ns_r <= mck_ns_nxt;
            end
            if (filt[0] && (mck_ns_nxt >= high_limit)) begin
              mck_state_r <= MCK_LOW;
              mck_ns_r <= '0;
              mck_drive_low_r <= 1'b1;
            end
          end
          MCK_LOW: begin
            mck_ns_r <= mck_ns_nxt;
            if (mck_ns_nxt >= low_limit) begin
              mck_state_r <= MCK_HIGH;
              mck_ns_r <= '0;
              mck_drive_low_r <= 1'b0;
            end
          end
          // Illegal code: return to idle with the line released
          default: begin
            mck_state_r <= MCK_IDLE;
            mck_ns_r <= '0;
            mck_drive_low_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Slave data setup before clock release
  // ----------------------------------------------------------------------
  assign setup_ns_nxt = setup_ns_r + CLK_PERIOD_NS;

  // Count the low time once data is set, then release
  // Release stays up until the slave drops its stretch or sets data again
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      setup_busy_r <= 1'b0;
      setup_ns_r <= '0;
      slave_release_o <= 1'b0;
    end else if (ce_i) begin
      if (!slave_stretch_i) begin
        setup_busy_r <= 1'b0;
        setup_ns_r <= '0;
        slave_release_o <= 1'b0;
      end else if (slave_data_set_i && !setup_busy_r) begin
        setup_busy_r <= 1'b1;
        setup_ns_r <= CLK_PERIOD_NS;
        slave_release_o <= 1'b0;
      end else if (setup_busy_r) begin
        setup_ns_r <= setup_ns_nxt;
        if (setup_ns_r >= low_limit) begin
          setup_busy_r <= 1'b0;
          slave_release_o <= 1'b1;
        end
      end
    end
  end

  // Clock line pulled low by the master or a stretching slave
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      scl_oe_o <= 1'b0;
    end else if (ce_i) begin
      scl_oe_o <= mck_drive_low_r ||
                  (slave_stretch_i && !slave_release_o);
    end
  end

endmodule
`default_nettype wire

/* sim/itc_timing_regs_props.sv */
// Port checker for the timing register block
`timescale 1ns/1ps
`default_nettype none

module itc_timing_regs_props (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [itc_pkg::DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic master_en_i,
  input wire logic slave_stretch_i,
  input wire logic slave_release_o,
  input wire logic osc_mode_i,
  input wire logic ext_clk_present_i,
  input wire logic use_osc_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // First access edge of a transfer
  sequence s_access;
    psel_i && penable_i && !pready_o && ce_i;
  endsequence
  property p_ready_once;
    s_access |=> pready_o ##1 !pready_o;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("ready not one pulse after access");
  property p_ready_cause;
    pready_o |-> $past(psel_i && penable_i);
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without access");
  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_rdata_idle;
    !pready_o |-> prdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside ready");
  property p_rdata_byte;
    pready_o |-> prdata_o[31:8] == 24'h0;
  endproperty
  a_rdata_byte: assert property (p_rdata_byte)
    else $error("upper read bits set");
  property p_open_drain;
    scl_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("clock pin driven high");
  property p_use_osc;
    $past(rstn_i) && $past(ce_i) |->
      use_osc_o == $past(osc_mode_i || !ext_clk_present_i);
  endproperty
  a_use_osc: assert property (p_use_osc)
    else $error("oscillator use wrong");
  property p_idle_free;
    (!master_en_i && !slave_stretch_i)[*3] |-> !scl_oe_o;
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("clock held while idle");
  property p_release_drop;
    slave_release_o && !slave_stretch_i && ce_i |=> !slave_release_o;
  endproperty
  a_release_drop: assert property (p_release_drop)
    else $error("release stuck");
  property p_release_stretch;
    $rose(slave_release_o) |-> slave_stretch_i;
  endproperty
  a_release_stretch: assert property (p_release_stretch)
    else $error("release without stretch");
endmodule

bind itc_timing_regs itc_timing_regs_props u_props (
  .mclk_i, .rstn_i, .ce_i, .psel_i, .penable_i, .prdata_o, .pready_o,
  .pslverr_o, .scl_o, .scl_oe_o, .master_en_i, .slave_stretch_i,
  .slave_release_o, .osc_mode_i, .ext_clk_present_i, .use_osc_o
);
`default_nettype wire

/* sim/itc_slave_model.sv */
// Slave devices sharing the local I2C lines
`timescale 1ns/1ps
`default_nettype none

module itc_slave_model (
  input wire logic mclk_i,
  input wire logic scl_oe_i,
  output logic scl_line_o,
  output logic sda_line_o
);
  logic hold_scl = 1'b0;
  logic sda_low = 1'b0;
  // Open drain lines with pull-ups
  assign scl_line_o = !(scl_oe_i || hold_scl);
  assign sda_line_o = !sda_low;
  // Pull data low for n cycles
  task automatic dip(input int n);
    sda_low <= 1'b1;
    repeat (n) @(posedge mclk_i);
    sda_low <= 1'b0;
  endtask
  // Slow slave holds the clock low
  task automatic stretch(input int n);
    hold_scl <= 1'b1;
    repeat (n) @(posedge mclk_i);
    hold_scl <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/itc_timing_regs_test.sv */
// Testbench for the timing register block
`timescale 1ns/1ps
`default_nettype none

module itc_timing_regs_test;
  import itc_pkg::*;
  logic mclk_i = 0, rstn_i = 0, ce_i = 1, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, pready_o, pslverr_o, er, scl_line, sda_line;
  logic [7:0] paddr_i = 0, general_purpose_bits_o;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic scl_o, scl_oe_o, scl_in_o, sda_in_o, slave_release_o, use_osc_o;
  logic master_en_i = 0, slave_stretch_i = 0, slave_data_set_i = 0;
  logic osc_mode_i = 0, ext_clk_present_i = 1;
  logic [1:0] osc_freq_sel_o;
  int n_fail = 0, checks_done = 0, n;

  itc_timing_regs uut (
    .mclk_i, .rstn_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_pin_i(scl_line),
    .sda_pin_i(sda_line), .scl_o, .scl_oe_o, .scl_in_o, .sda_in_o,
    .master_en_i, .slave_stretch_i, .slave_data_set_i, .slave_release_o,
    .osc_mode_i, .ext_clk_present_i, .osc_freq_sel_o, .use_osc_o,
    .general_purpose_bits_o
  );
  itc_slave_model sm (
    .mclk_i, .scl_oe_i(scl_oe_o), .scl_line_o(scl_line),
    .sda_line_o(sda_line)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Clock of 20 ns
  initial forever #10 mclk_i = ~mclk_i;
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_rng(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Count cycles until a signal reaches a level
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 600) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 600) begin
      n_fail++;
      end_of_test;
    end
  endtask
  // One APB transfer, called just after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1;
    @(posedge mclk_i);
    wait_for(pready_o, 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge mclk_i);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, rd);
  endtask
  task watch(input int k);
    n = 0;
    repeat (k) begin
      @(posedge mclk_i);
      if (sda_in_o === 1'b0) n++;
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1;
    rdc("ctrl", 8'h40, 32'h17);
    rdc("high", 8'h44, 32'h82);
    rdc("low", 8'h48, 32'h82);
    rdc("gp", 8'h4c, 32'h0);
    rdc("clksrc", 8'h50, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h40 + 8'(4 * i), 32'hffffffff);
      chk("werr", 0, {31'h0, er});
      rdc("rw", 8'h40 + 8'(4 * i), (i == 4) ? 32'h1f : 32'hff);
    end
    chk("gpo", 32'hff, {24'h0, general_purpose_bits_o});
    chk("fsel", 32'h3, {30'h0, osc_freq_sel_o});
    apb(1, 8'h54, 32'h5a);
    chk("unmapped", 1, {31'h0, er});
    apb(0, 8'h41, 0);
    chk("misaligned", 1, {31'h0, er});
    chk("misdata", 0, rd);
    // Master clock with high 4 and low 2 units
    apb(1, 8'h40, 32'h01);
    apb(1, 8'h44, 32'h04);
    apb(1, 8'h48, 32'h02);
    master_en_i <= 1;
    wait_for(scl_oe_o, 1'b1);
    wait_for(scl_oe_o, 1'b0);
    chk_rng("low time", 5, 5, n);
    wait_for(scl_oe_o, 1'b1);
    chk_rng("high time", 10, 16, n);
    wait_for(scl_oe_o, 1'b0);
    sm.stretch(15);
    wait_for(scl_oe_o, 1'b1);
    chk_rng("stretched", 25, 36, n + 15);
    master_en_i <= 0;
    repeat (5) @(posedge mclk_i);
    chk("idle", 0, {31'h0, scl_oe_o});
    // Glitch of 60 ns rejected, 120 ns passed at depth 7
    apb(1, 8'h40, 32'h07);
    fork
      sm.dip(3);
      watch(15);
    join
    chk("glitch", 0, n);
    fork
      sm.dip(6);
      watch(15);
    join
    chk_rng("pulse", 1, 15, n);
    // Data frozen 200 ns after a clock fall, filtering off
    apb(1, 8'h40, 32'h40);
    fork
      sm.stretch(20);
      sm.dip(20);
    join_none
    watch(8);
    chk("hold", 0, n);
    chk("sclin", 0, {31'h0, scl_in_o});
    watch(12);
    chk_rng("held", 5, 7, n);
    // Slave setup interval from low count
    slave_stretch_i <= 1;
    repeat (3) @(posedge mclk_i);
    chk("stretch", 1, {31'h0, scl_oe_o});
    slave_data_set_i <= 1;
    @(posedge mclk_i);
    slave_data_set_i <= 0;
    wait_for(slave_release_o, 1'b1);
    chk_rng("setup", 4, 8, n);
    slave_stretch_i <= 0;
    repeat (3) @(posedge mclk_i);
    chk("freed", 0, {31'h0, scl_oe_o});
    for (int i = 0; i < 4; i++) begin
      {osc_mode_i, ext_clk_present_i} <= 2'(i);
      repeat (2) @(posedge mclk_i);
      chk("useosc", {31'h0, i[1] | !i[0]}, {31'h0, use_osc_o});
    end
    // A low clock enable freezes the outputs
    ce_i <= 0;
    {osc_mode_i, ext_clk_present_i} <= 2'h1;
    repeat (3) @(posedge mclk_i);
    chk("frozen", 1, {31'h0, use_osc_o});
    ce_i <= 1;
    repeat (2) @(posedge mclk_i);
    chk("thawed", 0, {31'h0, use_osc_o});
    end_of_test;
  end
endmodule
`default_nettype wire
